// *** dv/desc_emu_chk_sva.sv ***
// Purpose: Port checker for the descriptor RAM emulation block.
// Assumes: One clock; srst_i is the power-on reset.
// Notes:   Descriptor overrides are judged only while the language flag shows emulation active.
`default_nettype none
module desc_emu_chk (
    input wire logic                    sys_clk_i,
    input wire logic                    srst_i,
    input wire logic                    hsel_i,
    input wire logic [1:0]              htrans_i,
    input wire logic                    hwrite_i,
    input wire logic                    hready_i,
    input wire logic                    hreadyout_o,
    input wire logic                    hresp_o,
    input wire desc_emu_pkg::desc_req_t desc_req_i,
    input wire desc_emu_pkg::desc_rsp_t desc_rsp_o,
    input wire desc_emu_pkg::sys_cfg_t  sys_cfg_o,
    input wire logic                    lang_id_supported_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import desc_emu_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    wire logic tk  = hsel_i && hready_i && htrans_i[1];
    wire logic rd  = tk && !hwrite_i;
    wire logic dv  = desc_req_i.valid && lang_id_supported_o;
    wire logic dev = desc_req_i.kind inside {DK_HS_DEV, DK_FS_DEV};
    wire logic cfg = desc_req_i.kind inside {DK_HS_CFG, DK_FS_CFG};
    property p_read_wait; rd |=> !hreadyout_o ##1 hreadyout_o; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_write_zero; tk && hwrite_i |=> hreadyout_o; endproperty
    a_write_zero: assert property (p_write_zero) else $error("write stalled");
    property p_okay; hresp_o == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_fall; $fell(hreadyout_o) |-> $past(rd); endproperty
    a_fall: assert property (p_fall) else $error("stall without read");
    property p_rsp; desc_rsp_o.valid == $past(desc_req_i.valid); endproperty
    a_rsp: assert property (p_rsp) else $error("response not one cycle after request");
    property p_dev_size;
        dv && dev && desc_req_i.idx == 10'h000 |=> !desc_rsp_o.present || desc_rsp_o.data == 8'h12;
    endproperty
    a_dev_size: assert property (p_dev_size) else $error("device size byte wrong");
    property p_dev_type;
        dv && dev && desc_req_i.idx == 10'h001 |=> !desc_rsp_o.present || desc_rsp_o.data == 8'h01;
    endproperty
    a_dev_type: assert property (p_dev_type) else $error("device type byte wrong");
    property p_cfg_type;
        dv && cfg && desc_req_i.idx == 10'h001 |=> !desc_rsp_o.present || desc_rsp_o.data == 8'h02;
    endproperty
    a_cfg_type: assert property (p_cfg_type) else $error("config type byte wrong");
    property p_bad_kind; dv && desc_req_i.kind > DK_FS_CFG |=> desc_rsp_o.valid && !desc_rsp_o.present; endproperty
    a_bad_kind: assert property (p_bad_kind) else $error("unknown kind served");
    property p_por;
        $fell(srst_i) |-> sys_cfg_o == '0 && !lang_id_supported_o && !desc_rsp_o.valid && hreadyout_o;
    endproperty
    a_por: assert property (p_por) else $error("power-on reset left state");
    c_read: cover property (rd);
    c_dev: cover property (dv && dev);
    c_refuse: cover property (desc_rsp_o.valid && !desc_rsp_o.present);
endmodule

bind descriptor_ram_emulation desc_emu_chk chk_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .desc_req_i(desc_req_i),
    .desc_rsp_o(desc_rsp_o), .sys_cfg_o(sys_cfg_o), .lang_id_supported_o(lang_id_supported_o)
);
`default_nettype wire

// *** dv/descriptor_ram_emulation_tb_top.sv ***
// Purpose: Self-checking bench for the descriptor RAM emulation block.
// Assumes: Host model drives the register bus; the bench drives descriptor requests.
// Notes:   With emulation off every request is taken as served from the memory path.
`default_nettype none
`include "desc_emu_cfg.svh"
module descriptor_ram_emulation_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import desc_emu_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        soft_rst = 1'b0;
    logic        present = 1'b0;
    logic [7:0]  cbyte = 8'h00;
    sys_cfg_t    ccfg = '0;
    desc_req_t   req = '0;
    desc_rsp_t   rsp;
    sys_cfg_t    scfg;
    logic        lang, hsel, hwrite, hready, rw;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [95:0] t;
    logic [7:0]  mem[512];
    int          len[10] = '{4, 6, 0, 0, 0, 0, 18, 18, 18, 0};
    int          miscompares = 0;
    int          checks = 0;
    int unsigned seed_ret;
    always #2.5 clk = ~clk;
    descriptor_ram_emulation dut_u (
        .sys_clk_i(clk), .srst_i(srst), .soft_rst_i(soft_rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .cfgmem_present_i(present),
        .cfgmem_cfg_i(ccfg), .cfgmem_byte_i(cbyte), .desc_req_i(req), .desc_rsp_o(rsp),
        .sys_cfg_o(scfg), .lang_id_supported_o(lang)
    );
    host_ahb_model host_u (
        .clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
        .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata)
    );
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] q;
        host_u.xfer(1'b1, a, v, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        host_u.xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    // Reference answer: packing starts at zero and each slot rounds up to a whole word.
    function automatic logic [9:0] model(int k, int i, logic emu, logic [7:0] cb);
        int s = 0;
        logic [7:0] b;
        if (!emu)
            return {2'b11, cb};
        if (k > 9)
            return 10'h200;
        for (int j = 0; j < k; j++) s += (len[j] + 3) / 4 * 4;
        if (i >= len[k] || (k == 0 && len[1] + len[2] + len[3] + len[4] + len[5] == 0))
            return 10'h200;
        b = mem[s + i];
        if ((k == 6 || k == 8) && i < 2)
            b = (i == 0) ? 8'h12 : 8'h01;
        if ((k == 7 || k == 9) && i == 1)
            b = 8'h02;
        return {2'b11, b};
    endfunction
    task automatic sweep(input logic emu);
        logic [9:0] q[$];
        logic [7:0] b;
        for (int n = 0; n <= 220; n++)
        begin
            @(posedge clk);
            b = 8'($urandom);
            req <= (n < 220) ? desc_req_t'({1'b1, 4'(n / 20), 10'(n % 20)}) : desc_req_t'('0);
            cbyte <= b;
            q.push_back(model(n / 20, n % 20, emu, b));
            @(negedge clk);
            if (n > 0)
                check(rsp, q.pop_front());
        end
        @(posedge clk);
    endtask
    initial
    begin
        #20000;
        miscompares++;
        complete_run();
    end
    initial
    begin
        seed_ret = $urandom(32'heeb331a2);
        t = {$urandom, $urandom, $urandom};
        ccfg <= t[92:0];
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk(`OFS_HARDWARE_CONFIG, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd_chk(8'h3c, 32'h0);
        wr(`OFS_STATION_ADDR_UP, 32'h0000_5a3c);
        wr(`OFS_STATION_ADDR_LO, 32'h1234_9876);
        wr(`OFS_INDICATOR_CFG, 32'h1);
        wr(`OFS_PIN_WAKE, 32'h0000_05a5);
        wr(`OFS_HS_LENGTHS, 32'h0012_0012);
        wr(`OFS_FS_LENGTHS, 32'h0000_0012);
        wr(`OFS_STR_LENGTHS_LO, 32'h0000_0604);
        wr(`OFS_STR_LENGTHS_HI, 32'h0);
        wr(`OFS_FLAG_ATTRIBUTES, 32'h0);
        wr(`OFS_HARDWARE_CONFIG, 32'h4);
        wr(`OFS_DATA_PORT_ADDR, 32'h0);
        for (int i = 0; i < 80; i++) mem[i] = 8'($urandom);
        for (int b = 12; b < 60; b += 40)
        begin
            {mem[b + 2], mem[b + 3], mem[b + 7], mem[b + 17]} = 32'h0002_4001;
            {mem[b + 15], mem[b + 16]} = 16'h0000;
        end
        mem[38] = 8'h00;
        for (int w = 0; w < 20; w++)
        begin
            wr(`OFS_DATA_PORT_DATA, {mem[4 * w + 3], mem[4 * w + 2], mem[4 * w + 1], mem[4 * w]});
        end
        rw = mem[39][5];
        wr(`OFS_HARDWARE_CONFIG, 32'h1);
        wr(`OFS_HARDWARE_CONFIG, 32'h3);
        sweep(1'b1);
        check(scfg.station_addr, 48'h5a3c_1234_9876);
        check({scfg.indicator_select, scfg.pin_wake_enables, scfg.remote_wake_flag}, {1'b1, 11'h5a5, rw});
        check(lang, 1'b1);
        rd_chk(`OFS_FLAG_ATTRIBUTES, {22'h0, rw, 9'h0});
        rd_chk(`OFS_EMU_STATUS, {29'h0, 2'b11, rw});
        present <= 1'b1;
        rd_chk(`OFS_FLAG_ATTRIBUTES, 32'h0);
        wr(`OFS_FLAG_ATTRIBUTES, 32'hffff_ffff);
        present <= 1'b0;
        rd_chk(`OFS_FLAG_ATTRIBUTES, {22'h0, rw, 9'h0});
        // Dropping the only string leaves the language slot reserved but unserved.
        wr(`OFS_STR_LENGTHS_LO, 32'h0000_0004);
        len[1] = 0;
        sweep(1'b1);
        check(lang, 1'b0);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        @(posedge clk);
        rd_chk(`OFS_STATION_ADDR_LO, 32'h1234_9876);
        rd_chk(`OFS_HARDWARE_CONFIG, 32'h3);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk(`OFS_HARDWARE_CONFIG, 32'h0);
        rd_chk(`OFS_STATION_ADDR_LO, 32'h0);
        sweep(1'b0);
        check(scfg, ccfg);
        complete_run();
    end
endmodule
`default_nettype wire

// *** dv/host_ahb_model.sv ***
// Purpose: Host driver stand-in that reaches the registers as an AHB-Lite master.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   Single word transfers only; released write data is inverted so stale data never looks valid.
`default_nettype none
module host_ahb_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        hsel_o = 1'b1;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr_o <= {24'h0, a};
        hwrite_o <= w;
        htrans_o <= 2'b10;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'b00;
        hwdata_o <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
        hwdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// *** hw/desc_emu_cfg.svh ***
// Purpose: Register map, field positions and fixed values of the descriptor RAM emulation block.
// Assumes: Included by the design module and by the testbench.
// Notes:   Byte offsets on the AHB-Lite bus; each register is one aligned 32-bit word.
`ifndef DESC_EMU_CFG_SVH
`define DESC_EMU_CFG_SVH

`define OFS_HARDWARE_CONFIG   8'h00
`define OFS_STATION_ADDR_UP   8'h04
`define OFS_STATION_ADDR_LO   8'h08
`define OFS_INDICATOR_CFG     8'h0c
`define OFS_PIN_WAKE          8'h10
`define OFS_HS_LENGTHS        8'h14
`define OFS_FS_LENGTHS        8'h18
`define OFS_STR_LENGTHS_LO    8'h1c
`define OFS_STR_LENGTHS_HI    8'h20
`define OFS_FLAG_ATTRIBUTES   8'h24
`define OFS_DATA_PORT_ADDR    8'h28
`define OFS_DATA_PORT_DATA    8'h2c
`define OFS_EMU_STATUS        8'h30

`define HWC_EMU_BIT           0
`define HWC_PROTECT_BIT       1
`define HWC_RAM_TEST_BIT      2
`define HWC_MASK              32'h0000_0007
`define STA_UP_MASK           32'h0000_ffff
`define IND_SELECT_BIT        0
`define PIN_WAKE_MASK         32'h0000_07ff
`define FLAG_RWAKE_BIT        9
`define BMATTR_RWAKE_BIT      5
`define BMATTR_OFFSET         16'h0007

`define DEV_SIZE_VALUE        8'h12
`define DEV_TYPE_VALUE        8'h01
`define CFG_TYPE_VALUE        8'h02
`define SIZE_BYTE_IDX         10'h000
`define TYPE_BYTE_IDX         10'h001

`define DWORD_ROUND           16'h0003
`define DWORD_MASK            16'hfffc
`define ZERO_WORD             32'h0000_0000

`endif

// *** hw/desc_emu_pkg.sv ***
// Purpose: Shared types of the descriptor RAM emulation block.
// Assumes: desc_emu_cfg.svh holds the numeric constants.
// Notes:   Descriptor kinds follow the packing order inside the RAM.
`default_nettype none

package desc_emu_pkg;

    typedef enum logic [3:0] {
        DK_LANG_ID  = 4'h0,
        DK_STRING1  = 4'h1,
        DK_STRING2  = 4'h2,
        DK_STRING3  = 4'h3,
        DK_STRING4  = 4'h4,
        DK_STRING5  = 4'h5,
        DK_HS_DEV   = 4'h6,
        DK_HS_CFG   = 4'h7,
        DK_FS_DEV   = 4'h8,
        DK_FS_CFG   = 4'h9
    } desc_kind_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_READ = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic       valid;
        desc_kind_t kind;
        logic [9:0] idx;
    } desc_req_t;

    typedef struct packed {
        logic       valid;
        logic       present;
        logic [7:0] data;
    } desc_rsp_t;

    typedef struct packed {
        logic [47:0] station_addr;
        logic        indicator_select;
        logic [10:0] pin_wake_enables;
        logic        remote_wake_flag;
        logic [31:0] flag_attributes;
    } sys_cfg_t;

endpackage

`default_nettype wire

// *** hw/descriptor_ram_emulation.sv ***
// Purpose: Descriptor RAM, attribute and control registers that let the device run without configuration memory.
// Assumes: One clock; srst_i is power-on reset, soft_rst_i any other system reset, both synchronous.
// Notes:   Operation
// Operation
// - A RAM write of configuration bmAttributes overwrites the remote wake flag.
// - With configuration memory, flag attributes read as zero and ignore writes.
// - A 512-byte descriptor RAM is written through the data port registers.
// - RAM location zero always holds the language identifier slot.
// - Device descriptor length is 0 or 18 (the block serves any length set in bits 7:0 of the length registers); size byte is sent as 0x12.
// - Device descriptor type byte is sent as 0x1.
// - Configuration descriptor type byte is sent as 0x2.
// - With all string lengths zero, no language identifier descriptor is served.
// - With emulation enabled, descriptors come from the RAM; lengths, flags and fields come from registers.
// - Protected state survives every reset except power-on.
`default_nettype none
`include "desc_emu_cfg.svh"

module descriptor_ram_emulation #(
    parameter int RAM_BYTES = 512
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   srst_i,
    input  wire logic                   soft_rst_i,
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic      [31:0]            hrdata_o,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    input  wire logic                   cfgmem_present_i,
    input  wire desc_emu_pkg::sys_cfg_t cfgmem_cfg_i,
    input  wire logic [7:0]             cfgmem_byte_i,
    input  wire desc_emu_pkg::desc_req_t desc_req_i,
    output desc_emu_pkg::desc_rsp_t     desc_rsp_o,
    output desc_emu_pkg::sys_cfg_t      sys_cfg_o,
    output logic                        lang_id_supported_o
);
    import desc_emu_pkg::*;

    localparam int RAM_WORDS = RAM_BYTES / 4;
    localparam int AW        = $clog2(RAM_WORDS);
    localparam int NDESC     = 10;

    function automatic logic [15:0] dword_align(input logic [15:0] n);
        dword_align = (n + `DWORD_ROUND) & `DWORD_MASK;
    endfunction

    function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] lane);
        lane_byte = w[{lane, 3'b000} +: 8];
    endfunction

    // The RAM has no reset at all, so it keeps its contents through every reset.
    logic [31:0]   ram_q [RAM_WORDS];
    logic          ram_we;
    logic [AW-1:0] ram_waddr;

    logic [31:0]   hwc_q,  hwc_d;
    logic [31:0]   sta_up_q, sta_up_d;
    logic [31:0]   sta_lo_q, sta_lo_d;
    logic [31:0]   ind_q,  ind_d;
    logic [31:0]   wake_q, wake_d;
    logic [31:0]   hs_q,   hs_d;
    logic [31:0]   fs_q,   fs_d;
    logic [31:0]   str0_q, str0_d;
    logic [31:0]   str1_q, str1_d;
    logic [31:0]   flag_q, flag_d;
    logic [AW-1:0] dp_addr_q, dp_addr_d;

    bus_state_t    state_q, state_d;
    logic          wr_pend_q, wr_pend_d;
    logic [7:0]    addr_q, addr_d;
    logic [31:0]   hrdata_q, hrdata_d;
    logic          ready_q, ready_d;
    logic          hresp_q;

    desc_rsp_t     rsp_q, rsp_d;
    sys_cfg_t      cfg_q, cfg_d;
    logic          lang_q, lang_d;

    logic [15:0]   len_a   [NDESC];
    logic [15:0]   start_a [NDESC];
    logic          emu_on;
    logic          lang_ok;
    logic          accept;
    logic [31:0]   rd_word;
    logic [15:0]   bm_addr;
    logic          bm_valid;
    logic [7:0]    bm_byte;
    logic [15:0]   rsp_addr;
    logic [15:0]   rsp_len;
    logic [7:0]    rsp_byte;

    assign emu_on = hwc_q[`HWC_EMU_BIT];
    assign accept = hsel_i & hready_i & htrans_i[1];
    assign bm_byte = lane_byte(hwdata_i, bm_addr[1:0]);

    // Descriptor lengths and their start offsets, packed in fixed order from location zero.
    always_comb
    begin
        len_a[DK_LANG_ID] = {8'h00, str0_q[7:0]};
        len_a[DK_STRING1] = {8'h00, str0_q[15:8]};
        len_a[DK_STRING2] = {8'h00, str0_q[23:16]};
        len_a[DK_STRING3] = {8'h00, str0_q[31:24]};
        len_a[DK_STRING4] = {8'h00, str1_q[7:0]};
        len_a[DK_STRING5] = {8'h00, str1_q[15:8]};
        len_a[DK_HS_DEV]  = {8'h00, hs_q[7:0]};
        len_a[DK_HS_CFG]  = hs_q[31:16];
        len_a[DK_FS_DEV]  = {8'h00, fs_q[7:0]};
        len_a[DK_FS_CFG]  = fs_q[31:16];
        start_a[0]        = 16'h0000;
        for (int i = 1; i < NDESC; i++)
        begin
            start_a[i] = start_a[i-1] + dword_align(len_a[i-1]);
        end
    end

    assign lang_ok = (len_a[DK_STRING1] != 16'h0000) | (len_a[DK_STRING2] != 16'h0000) |
                     (len_a[DK_STRING3] != 16'h0000) | (len_a[DK_STRING4] != 16'h0000) |
                     (len_a[DK_STRING5] != 16'h0000);

    // Location of the bmAttributes byte: HS configuration, else FS configuration.
    always_comb
    begin
        if (len_a[DK_HS_CFG] != 16'h0000)
        begin
            bm_addr  = start_a[DK_HS_CFG] + `BMATTR_OFFSET;
            bm_valid = 1'b1;
        end
        else
        begin
            bm_addr  = start_a[DK_FS_CFG] + `BMATTR_OFFSET;
            bm_valid = len_a[DK_FS_CFG] != 16'h0000;
        end
    end

    always_comb
    begin
        unique case (addr_q)
            `OFS_HARDWARE_CONFIG: rd_word = hwc_q;
            `OFS_STATION_ADDR_UP: rd_word = sta_up_q;
            `OFS_STATION_ADDR_LO: rd_word = sta_lo_q;
            `OFS_INDICATOR_CFG:   rd_word = ind_q;
            `OFS_PIN_WAKE:        rd_word = wake_q;
            `OFS_HS_LENGTHS:      rd_word = hs_q;
            `OFS_FS_LENGTHS:      rd_word = fs_q;
            `OFS_STR_LENGTHS_LO:  rd_word = str0_q;
            `OFS_STR_LENGTHS_HI:  rd_word = str1_q;
            `OFS_FLAG_ATTRIBUTES: rd_word = cfgmem_present_i ? `ZERO_WORD : flag_q;
            `OFS_DATA_PORT_ADDR:  rd_word = {{(32-AW){1'b0}}, dp_addr_q};
            `OFS_DATA_PORT_DATA:  rd_word = ram_q[dp_addr_q];
            `OFS_EMU_STATUS:      rd_word = {29'h0000_0000, emu_on, lang_ok, flag_q[`FLAG_RWAKE_BIT]};
            default:              rd_word = `ZERO_WORD;
        endcase
    end

    // Bus slave and register writes. Reads take one wait state so that a write
    // landing in the read's address phase is already visible to that read.
    always_comb
    begin
        hwc_d     = hwc_q;
        sta_up_d  = sta_up_q;
        sta_lo_d  = sta_lo_q;
        ind_d     = ind_q;
        wake_d    = wake_q;
        hs_d      = hs_q;
        fs_d      = fs_q;
        str0_d    = str0_q;
        str1_d    = str1_q;
        flag_d    = flag_q;
        dp_addr_d = dp_addr_q;
        state_d   = state_q;
        addr_d    = addr_q;
        hrdata_d  = hrdata_q;
        ready_d   = ready_q;
        wr_pend_d = 1'b0;
        ram_we    = 1'b0;
        ram_waddr = dp_addr_q;

        if (wr_pend_q)
        begin
            unique case (addr_q)
                `OFS_HARDWARE_CONFIG: hwc_d    = hwdata_i & `HWC_MASK;
                `OFS_STATION_ADDR_UP: sta_up_d = hwdata_i & `STA_UP_MASK;
                `OFS_STATION_ADDR_LO: sta_lo_d = hwdata_i;
                `OFS_INDICATOR_CFG:   ind_d    = hwdata_i;
                `OFS_PIN_WAKE:        wake_d   = hwdata_i & `PIN_WAKE_MASK;
                `OFS_HS_LENGTHS:      hs_d     = hwdata_i;
                `OFS_FS_LENGTHS:      fs_d     = hwdata_i;
                `OFS_STR_LENGTHS_LO:  str0_d   = hwdata_i;
                `OFS_STR_LENGTHS_HI:  str1_d   = hwdata_i;
                `OFS_FLAG_ATTRIBUTES:
                begin
                    if (!cfgmem_present_i)
                    begin
                        flag_d = hwdata_i;
                    end
                end
                `OFS_DATA_PORT_ADDR:  dp_addr_d = hwdata_i[AW-1:0];
                `OFS_DATA_PORT_DATA:
                begin
                    // The RAM only takes data while test mode opens it to the data port.
                    if (hwc_q[`HWC_RAM_TEST_BIT])
                    begin
                        ram_we    = 1'b1;
                        dp_addr_d = dp_addr_q + 1'b1;
                        if (bm_valid && (bm_addr[AW+1:2] == dp_addr_q))
                        begin
                            flag_d[`FLAG_RWAKE_BIT] = bm_byte[`BMATTR_RWAKE_BIT];
                        end
                    end
                end
                default: ;
            endcase
        end

        unique case (state_q)
            BUS_IDLE:
            begin
                if (accept && !hwrite_i)
                begin
                    addr_d  = haddr_i[7:0];
                    ready_d = 1'b0;
                    state_d = BUS_READ;
                end
                else if (accept)
                begin
                    addr_d    = haddr_i[7:0];
                    wr_pend_d = 1'b1;
                end
            end
            BUS_READ:
            begin
                hrdata_d = rd_word;
                ready_d  = 1'b1;
                state_d  = BUS_IDLE;
            end
            default:
            begin
                ready_d = 1'b1;
                state_d = BUS_IDLE;
            end
        endcase

        // A non power-on reset always clears the data port address, and clears the other registers unless protection is set.
        if (soft_rst_i)
        begin
            dp_addr_d = '0;
            if (!hwc_q[`HWC_PROTECT_BIT])
            begin
                hwc_d    = `ZERO_WORD;
                sta_up_d = `ZERO_WORD;
                sta_lo_d = `ZERO_WORD;
                ind_d    = `ZERO_WORD;
                wake_d   = `ZERO_WORD;
                hs_d     = `ZERO_WORD;
                fs_d     = `ZERO_WORD;
                str0_d   = `ZERO_WORD;
                str1_d   = `ZERO_WORD;
                flag_d   = `ZERO_WORD;
            end
        end
    end

    // Descriptor responder: one request per cycle, answered on the next edge.
    always_comb
    begin
        rsp_len  = 16'h0000;
        rsp_addr = 16'h0000;
        if (desc_req_i.kind <= DK_FS_CFG)
        begin
            rsp_len  = len_a[desc_req_i.kind];
            rsp_addr = start_a[desc_req_i.kind] + {6'h00, desc_req_i.idx};
        end
        rsp_byte = lane_byte(ram_q[rsp_addr[AW+1:2]], rsp_addr[1:0]);

        rsp_d.valid = desc_req_i.valid;
        if (emu_on)
        begin
            rsp_d.present = ({6'h00, desc_req_i.idx} < rsp_len) &&
                            !((desc_req_i.kind == DK_LANG_ID) && !lang_ok);
            rsp_d.data    = rsp_byte;
            if ((desc_req_i.kind == DK_HS_DEV) || (desc_req_i.kind == DK_FS_DEV))
            begin
                if (desc_req_i.idx == `SIZE_BYTE_IDX)
                begin
                    rsp_d.data = `DEV_SIZE_VALUE;
                end
                if (desc_req_i.idx == `TYPE_BYTE_IDX)
                begin
                    rsp_d.data = `DEV_TYPE_VALUE;
                end
            end
            if (((desc_req_i.kind == DK_HS_CFG) || (desc_req_i.kind == DK_FS_CFG)) &&
                (desc_req_i.idx == `TYPE_BYTE_IDX))
            begin
                rsp_d.data = `CFG_TYPE_VALUE;
            end
            // An absent byte reads as zero, so unwritten RAM never leaks to the host.
            if (!rsp_d.present)
            begin
                rsp_d.data = '0;
            end
        end
        else
        begin
            rsp_d.present = 1'b1;
            rsp_d.data    = cfgmem_byte_i;
        end

        if (emu_on)
        begin
            cfg_d.station_addr     = {sta_up_q[15:0], sta_lo_q};
            cfg_d.indicator_select = ind_q[`IND_SELECT_BIT];
            cfg_d.pin_wake_enables = wake_q[10:0];
            cfg_d.remote_wake_flag = flag_q[`FLAG_RWAKE_BIT];
            cfg_d.flag_attributes  = flag_q;
        end
        else
        begin
            cfg_d = cfgmem_cfg_i;
        end
        lang_d = emu_on & lang_ok;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (ram_we)
        begin
            ram_q[ram_waddr] <= hwdata_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            hwc_q     <= `ZERO_WORD;
            sta_up_q  <= `ZERO_WORD;
            sta_lo_q  <= `ZERO_WORD;
            ind_q     <= `ZERO_WORD;
            wake_q    <= `ZERO_WORD;
            hs_q      <= `ZERO_WORD;
            fs_q      <= `ZERO_WORD;
            str0_q    <= `ZERO_WORD;
            str1_q    <= `ZERO_WORD;
            flag_q    <= `ZERO_WORD;
            dp_addr_q <= '0;
            state_q   <= BUS_IDLE;
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hrdata_q  <= `ZERO_WORD;
            ready_q   <= 1'b1;
            hresp_q   <= 1'b0;
            rsp_q     <= '0;
            cfg_q     <= '0;
            lang_q    <= 1'b0;
        end
        else
        begin
            hwc_q     <= hwc_d;
            sta_up_q  <= sta_up_d;
            sta_lo_q  <= sta_lo_d;
            ind_q     <= ind_d;
            wake_q    <= wake_d;
            hs_q      <= hs_d;
            fs_q      <= fs_d;
            str0_q    <= str0_d;
            str1_q    <= str1_d;
            flag_q    <= flag_d;
            dp_addr_q <= dp_addr_d;
            state_q   <= state_d;
            wr_pend_q <= wr_pend_d;
            addr_q    <= addr_d;
            hrdata_q  <= hrdata_d;
            ready_q   <= ready_d;
            hresp_q   <= 1'b0;
            rsp_q     <= rsp_d;
            cfg_q     <= cfg_d;
            lang_q    <= lang_d;
        end
    end

    assign hrdata_o            = hrdata_q;
    assign hreadyout_o         = ready_q;
    assign hresp_o             = hresp_q;
    assign desc_rsp_o          = rsp_q;
    assign sys_cfg_o           = cfg_q;
    assign lang_id_supported_o = lang_q;

endmodule

`default_nettype wire
